// ==== verilog/vot_map.svh ====
// Register offsets, field positions, reset values and pixel constants of the video offset block
`ifndef VOT_MAP_SVH
`define VOT_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define VOT_ADDR_MASK    8'hFC
`define VOT_ADDR_SRC     8'h00
`define VOT_ADDR_GAIN    8'h04
`define VOT_ADDR_OFFS    8'h08
`define VOT_ADDR_EXPO    8'h0C
`define VOT_ADDR_STAT    8'h10

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define VOT_TAP_LSB      12
`define VOT_STAT_PAT     0
`define VOT_STAT_FRM     1
`define VOT_STAT_CNT_LSB 16
`define VOT_LANE_W       8
`define VOT_LANES        4
`define VOT_GAIN_RST     13'h0400
`define VOT_GAIN_MIN     13'h0400
`define VOT_GAIN_UNITY   13'h0400
`define VOT_GAIN_X2      13'h0800
`define VOT_GAIN_FRAC    10
`define VOT_OFFS_RST     9'h000
`define VOT_PIX_MAX      10'h3FF
`define VOT_PIX_ONE      10'h001

// ----------------------------------------------------------------------------
// Video source codes and bus responses
// ----------------------------------------------------------------------------
`define VOT_SRC_VIDEO    4'h0
`define VOT_SRC_HRAMP    4'h4
`define VOT_SRC_VRAMP    4'h5
`define VOT_SRC_DRAMP    4'h6
`define VOT_SRC_LAST     4'h8
`define VOT_RESP_OKAY    2'h0
`define VOT_RESP_SLVERR  2'h2

`endif

// ==== verilog/vot_pkg.sv ====
// Types shared by the video offset and test pattern block
`default_nettype none
package vot_pkg;

  typedef logic [9:0]  vot_pix_t;
  typedef logic [12:0] vot_gain_t;
  typedef logic [8:0]  vot_offs_t;

  typedef struct packed {
    vot_pix_t col;
    vot_pix_t row;
    logic     lval_d;
  } vot_pat_state_t;

  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  src;
    vot_gain_t   gain;
    vot_offs_t   offs;
    logic [3:0]  tap;
    logic        expo;
    logic [15:0] frames;
    vot_pix_t    s1_pix;
    logic        s1_f;
    logic        s1_l;
    logic        s1_d;
    vot_pix_t    o_pix;
    logic        o_f;
    logic        o_l;
    logic        o_d;
    logic        pat_act;
    logic        expo_out;
  } vot_top_state_t;

endpackage : vot_pkg
`default_nettype wire

// ==== verilog/vot_pattern.sv ====
// Test pattern source: column and row counters and ramp selection
`include "vot_map.svh"
`timescale 1ns/1ps
`default_nettype none
module vot_pattern (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  input  wire logic            clk_en,
  // Sensor timing
  input  wire logic            sen_fval,
  input  wire logic            sen_lval,
  input  wire logic            sen_dval,
  // Pattern
  input  wire logic [3:0]      src_mode,
  output vot_pkg::vot_pix_t    pat_pix
);

  vot_pkg::vot_pat_state_t state_reg;
  vot_pkg::vot_pat_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (!sen_fval)
    begin
      state_next.col = '0;
      state_next.row = '0;
    end
    else
    begin
      if (sen_lval && sen_dval)
        state_next.col = vot_pkg::vot_pix_t'(state_reg.col + `VOT_PIX_ONE);
      // Row advances on the falling edge of line valid
      if (!sen_lval && state_reg.lval_d)
      begin
        state_next.row = vot_pkg::vot_pix_t'(state_reg.row + `VOT_PIX_ONE);
        state_next.col = '0;
      end
    end
    state_next.lval_d = sen_lval && sen_fval;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_reg <= '0;
    else if (clk_en)
      state_reg <= state_next;
  end

  // Ramps wrap at full scale; reserved codes give a black frame
  always_comb
  begin
    case (src_mode)
      `VOT_SRC_HRAMP: pat_pix = state_reg.col;
      `VOT_SRC_VRAMP: pat_pix = state_reg.row;
      `VOT_SRC_DRAMP: pat_pix = vot_pkg::vot_pix_t'(state_reg.col + state_reg.row);
      default:        pat_pix = '0;
    endcase
  end

  hramp_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (src_mode == `VOT_SRC_HRAMP && sen_fval && sen_lval && sen_dval) ##1
    (src_mode == `VOT_SRC_HRAMP && sen_fval && sen_lval && sen_dval)
    |-> pat_pix == vot_pkg::vot_pix_t'($past(pat_pix) + `VOT_PIX_ONE))
    else $error("horizontal ramp did not step by one");

  vramp_flat_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (src_mode == `VOT_SRC_VRAMP && sen_fval && sen_lval) ##1
    (src_mode == `VOT_SRC_VRAMP && sen_fval && sen_lval)
    |-> pat_pix == $past(pat_pix))
    else $error("vertical ramp changed within a line");

endmodule : vot_pattern
`default_nettype wire

// ==== verilog/vot_pixel_math.sv ====
// Pixel arithmetic: offset subtraction with clamp, fractional gain with saturation, bypass
`include "vot_map.svh"
`timescale 1ns/1ps
`default_nettype none
module vot_pixel_math (
  // Operands
  input  wire vot_pkg::vot_pix_t  pix_in,
  input  wire vot_pkg::vot_gain_t gain,
  input  wire vot_pkg::vot_offs_t offs,
  input  wire logic               bypass,
  // Result
  output vot_pkg::vot_pix_t       pix_out
);

  logic [10:0] diff;
  logic [9:0]  clamped;
  logic [22:0] product;
  logic [22:0] scaled;

  always_comb
  begin
    diff    = {1'b0, pix_in} - {2'b00, offs};
    // Negative results would wrap to bright values, so they stop at zero
    clamped = diff[10] ? '0 : diff[9:0];
    product = {13'h0000, clamped} * {10'h000, gain};
    scaled  = product >> `VOT_GAIN_FRAC;
    if (bypass)
      pix_out = pix_in;
    else if (scaled > 23'(`VOT_PIX_MAX))
      pix_out = `VOT_PIX_MAX;
    else
      pix_out = vot_pkg::vot_pix_t'(scaled);
  end

endmodule : vot_pixel_math
`default_nettype wire

// ==== verilog/vot_top.sv ====
// Video offset and test pattern stage with AXI4-Lite register access
//
// Function
// - Carry pixels with 10-bit precision throughout
// - Subtract programmable offset 0..511 from pixels
// - Inject pattern right after the digitizer
// - Source zero passes sensor video
// - Sources 4,5,6 give horizontal, vertical, diagonal ramps
// - Pattern modes bypass gain and offset
// - Readback keeps stored gain and offset
// - Return to video restores gain, offset, exposure
// - Gain multiplies pixel by setting over 1024
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`include "vot_map.svh"
`timescale 1ns/1ps
`default_nettype none
module vot_top (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Digitizer samples
  input  wire logic [9:0]  sen_pix,
  input  wire logic        sen_fval,
  input  wire logic        sen_lval,
  input  wire logic        sen_dval,
  // Processed video
  output logic [9:0]       vid_pix,
  output logic             vid_fval,
  output logic             vid_lval,
  output logic             vid_dval,
  output logic             expo_corr_en,
  output logic             pat_active,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // --------------------------------------------------------------------------
  // State and helpers
  // --------------------------------------------------------------------------
  vot_pkg::vot_top_state_t state_reg;
  vot_pkg::vot_top_state_t state_next;
  vot_pkg::vot_pix_t       pat_pix;
  vot_pkg::vot_pix_t       math_pix;
  logic                    bypass;
  logic [31:0]             rd_word;
  logic [1:0]              rd_resp;
  logic [31:0]             wr_merge;
  logic [3:0]              wr_src;

  function automatic logic [31:0] vot_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < `VOT_LANES; i++)
    begin
      if (strb[i])
        m[i*`VOT_LANE_W +: `VOT_LANE_W] = new_w[i*`VOT_LANE_W +: `VOT_LANE_W];
    end
    return m;
  endfunction : vot_merge

  function automatic logic vot_src_ok(input logic [3:0] s);
    return (s == `VOT_SRC_VIDEO) || (s >= `VOT_SRC_HRAMP && s <= `VOT_SRC_LAST);
  endfunction : vot_src_ok

  // Settings are never overwritten by a mode change; only their use is gated
  assign bypass = (state_reg.src != `VOT_SRC_VIDEO);

  // --------------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------------
  vot_pattern u_pattern (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .sen_fval (sen_fval),
    .sen_lval (sen_lval),
    .sen_dval (sen_dval),
    .src_mode (state_reg.src),
    .pat_pix  (pat_pix)
  );

  vot_pixel_math u_math (
    .pix_in  (state_reg.s1_pix),
    .gain    (state_reg.gain),
    .offs    (state_reg.offs),
    .bypass  (bypass),
    .pix_out (math_pix)
  );

  // --------------------------------------------------------------------------
  // Register read decode
  // --------------------------------------------------------------------------
  always_comb
  begin
    rd_word = '0;
    rd_resp = `VOT_RESP_OKAY;
    case (s_axi_araddr & `VOT_ADDR_MASK)
      `VOT_ADDR_SRC:  rd_word = 32'(state_reg.src);
      `VOT_ADDR_GAIN: rd_word = 32'(state_reg.gain);
      `VOT_ADDR_OFFS: rd_word = 32'(state_reg.offs) | (32'(state_reg.tap) << `VOT_TAP_LSB);
      `VOT_ADDR_EXPO: rd_word = 32'(state_reg.expo);
      `VOT_ADDR_STAT: rd_word = (32'(state_reg.pat_act) << `VOT_STAT_PAT) |
                                (32'(state_reg.s1_f) << `VOT_STAT_FRM) |
                                (32'(state_reg.frames) << `VOT_STAT_CNT_LSB);
      default:        rd_resp = `VOT_RESP_SLVERR;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    wr_merge   = '0;
    wr_src     = '0;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && state_reg.awready)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr & `VOT_ADDR_MASK;
    end
    if (s_axi_wvalid && state_reg.wready)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;

    // A write completes only once the previous response has been taken
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = `VOT_RESP_OKAY;
      case (state_reg.aw_addr)
        `VOT_ADDR_SRC:
        begin
          wr_src = 4'(vot_merge(32'(state_reg.src), state_reg.w_data, state_reg.w_strb));
          // Unsupported codes are dropped so the path never sits in an undefined mode
          if (vot_src_ok(wr_src))
            state_next.src = wr_src;
        end
        `VOT_ADDR_GAIN:
        begin
          wr_merge = vot_merge(32'(state_reg.gain), state_reg.w_data, state_reg.w_strb);
          state_next.gain = (vot_pkg::vot_gain_t'(wr_merge) < `VOT_GAIN_MIN) ?
                            `VOT_GAIN_MIN : vot_pkg::vot_gain_t'(wr_merge);
        end
        `VOT_ADDR_OFFS:
        begin
          wr_merge = vot_merge(32'(state_reg.offs) | (32'(state_reg.tap) << `VOT_TAP_LSB),
                               state_reg.w_data, state_reg.w_strb);
          state_next.offs = vot_pkg::vot_offs_t'(wr_merge);
          // Tap field is kept for readback; the offset applies to all taps
          state_next.tap  = 4'(wr_merge >> `VOT_TAP_LSB);
        end
        `VOT_ADDR_EXPO:
        begin
          wr_merge = vot_merge(32'(state_reg.expo), state_reg.w_data, state_reg.w_strb);
          state_next.expo = wr_merge[0];
        end
        `VOT_ADDR_STAT: state_next.bresp = `VOT_RESP_OKAY;
        default:        state_next.bresp = `VOT_RESP_SLVERR;
      endcase
    end
    state_next.awready = !state_next.aw_held;
    state_next.wready  = !state_next.w_held;

    // Read: one outstanding, answered the cycle after the address is taken
    if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
    if (s_axi_arvalid && state_reg.arready)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_word;
      state_next.rresp  = rd_resp;
    end
    state_next.arready = !state_next.rvalid;

    // Stage 1: source select right behind the digitizer
    state_next.s1_pix = bypass ? pat_pix : sen_pix;
    state_next.s1_f   = sen_fval;
    state_next.s1_l   = sen_lval;
    state_next.s1_d   = sen_dval;
    if (sen_fval && !state_reg.s1_f)
      state_next.frames = state_reg.frames + 16'h0001;

    // Stage 2: offset and gain, or bypass in pattern modes
    state_next.o_pix = math_pix;
    state_next.o_f   = state_reg.s1_f;
    state_next.o_l   = state_reg.s1_l;
    state_next.o_d   = state_reg.s1_d;

    state_next.pat_act  = (state_next.src != `VOT_SRC_VIDEO);
    state_next.expo_out = state_next.expo && !state_next.pat_act;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg      <= '0;
      state_reg.gain <= `VOT_GAIN_RST;
      state_reg.offs <= `VOT_OFFS_RST;
    end
    else if (clk_en)
      state_reg <= state_next;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign vid_pix       = state_reg.o_pix;
  assign vid_fval      = state_reg.o_f;
  assign vid_lval      = state_reg.o_l;
  assign vid_dval      = state_reg.o_d;
  assign expo_corr_en  = state_reg.expo_out;
  assign pat_active    = state_reg.pat_act;
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready  = state_reg.wready;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;
  assign s_axi_rvalid  = state_reg.rvalid;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  unity_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (!bypass && state_reg.gain == `VOT_GAIN_UNITY && state_reg.offs == `VOT_OFFS_RST)
    |=> vid_pix == $past(state_reg.s1_pix))
    else $error("unity path altered pixel");

  offset_sub_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (!bypass && state_reg.gain == `VOT_GAIN_UNITY && state_reg.s1_pix > 10'(state_reg.offs))
    |=> vid_pix == 10'($past(state_reg.s1_pix) - 10'($past(state_reg.offs))))
    else $error("offset not subtracted");

  clamp_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (!bypass && state_reg.s1_pix <= 10'(state_reg.offs)) |=> vid_pix == '0)
    else $error("dark pixel not clamped at zero");

  gain_double_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (!bypass && state_reg.gain == `VOT_GAIN_X2 && state_reg.offs == `VOT_OFFS_RST)
    |=> vid_pix == (($past(state_reg.s1_pix) > (`VOT_PIX_MAX >> 1)) ? `VOT_PIX_MAX :
                    10'($past(state_reg.s1_pix) << 1)))
    else $error("double gain wrong");

  video_src_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (state_reg.src == `VOT_SRC_VIDEO) |=> state_reg.s1_pix == $past(sen_pix) ##1
    vid_fval == $past(sen_fval, 2))
    else $error("sensor video not passed");

  pattern_inj_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (bypass && $stable(state_reg.src)) |=> state_reg.s1_pix == $past(pat_pix))
    else $error("pattern not injected at stage one");

  bypass_path_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (bypass && state_next.pat_act) |=> vid_pix == $past(state_reg.s1_pix) && pat_active)
    else $error("pattern mode not bypassing gain and offset");

  report_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (s_axi_arvalid && state_reg.arready && (s_axi_araddr & `VOT_ADDR_MASK) == `VOT_ADDR_GAIN)
    |=> s_axi_rvalid && s_axi_rdata == 32'($past(state_reg.gain)))
    else $error("gain readback differs from stored value");

  restore_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (state_reg.pat_act && !state_next.pat_act) |=> expo_corr_en == state_reg.expo && !bypass)
    else $error("video settings not restored");

  bresp_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst || !clk_en)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule : vot_top
`default_nettype wire

// ==== verification/vot_sen_model.sv ====
// Digitizer model: frames of lines with random data stalls
`timescale 1ns/1ps
`default_nettype none
module vot_sen_model #(
  parameter int LINES = 3,
  parameter int WIDTH = 8
) (
  // Clock and control
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       en,
  input  wire logic       start,
  input  wire logic [9:0] pix_in,
  // Digitizer outputs
  output logic            sen_fval,
  output logic            sen_lval,
  output logic            sen_dval,
  output logic [9:0]      sen_pix,
  output logic            busy
);
  int   ln;
  int   px;
  int   gap;
  logic dv;

  // Outside valid samples the data lines flip, so a stale copy never looks right
  always @(posedge sys_clk)
  begin
    dv = 1'b0;
    if (sys_rst)
    begin
      busy <= 1'b0;
      sen_fval <= 1'b0;
      sen_lval <= 1'b0;
      sen_dval <= 1'b0;
      sen_pix <= 10'h000;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      sen_fval <= 1'b1;
      ln <= 0;
      px <= 0;
      gap <= 2;
    end
    else if (busy && en)
    begin
      if (ln == LINES)
      begin
        sen_fval <= 1'b0;
        busy <= 1'b0;
      end
      else if (gap > 0)
        gap <= gap - 1;
      else if (px == WIDTH)
      begin
        sen_lval <= 1'b0;
        px <= 0;
        ln <= ln + 1;
        gap <= 1;
      end
      else
      begin
        dv = ($urandom % 4) != 0;
        sen_lval <= 1'b1;
        px <= px + int'(dv);
      end
      sen_dval <= dv;
      sen_pix <= dv ? pix_in : ~sen_pix;
    end
  end
endmodule : vot_sen_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench of the video offset and test pattern stage
`include "vot_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, start = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rd;
  logic [9:0]  pix_rnd = 10'h000, sen_pix, vid_pix;
  logic [1:0]  rsp, bresp, rresp;
  logic [31:0] rdata;
  logic        sen_fval, sen_lval, sen_dval, vid_fval, vid_lval, vid_dval, expo_corr_en, pat_active;
  logic        awready, wready, bvalid, arready, rvalid, busy, lv_d;
  logic [12:0] q0, q1;
  int          miscompares = 0, checked = 0, cyc = 0;
  int          m_src = 0, m_gain = 1024, m_offs = 0, col = 0, row = 0;
  int          ga[4] = '{1024, 2048, 1024 * 1023 / (1023 - 25), 8191};
  int          oa[4] = '{0, 0, 25, 511};

  always #5 sys_clk = ~sys_clk;

  vot_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .sen_pix(sen_pix),
    .sen_fval(sen_fval), .sen_lval(sen_lval), .sen_dval(sen_dval), .vid_pix(vid_pix),
    .vid_fval(vid_fval), .vid_lval(vid_lval), .vid_dval(vid_dval), .expo_corr_en(expo_corr_en),
    .pat_active(pat_active), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  vot_sen_model sen (.sys_clk(sys_clk), .sys_rst(sys_rst), .en(clk_en), .start(start),
    .pix_in(pix_rnd), .sen_fval(sen_fval), .sen_lval(sen_lval), .sen_dval(sen_dval),
    .sen_pix(sen_pix), .busy(busy));

  // ---------------------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------------------
  function automatic int f_exp(input int p);
    int d;
    case (m_src)
      4: return col;
      5: return row;
      6: return (col + row) % 1024;
      7, 8: return 0;
      default:
      begin
        d = (p > m_offs) ? p - m_offs : 0;
        d = d * m_gain / 1024;
        return (d > 1023) ? 1023 : d;
      end
    endcase
  endfunction : f_exp

  always @(posedge sys_clk)
  begin
    pix_rnd <= 10'($urandom);
    cyc = cyc + 1;
    if (sys_rst)
    begin
      q0 = 13'h0000;
      q1 = 13'h0000;
      col = 0;
      row = 0;
      lv_d = 1'b0;
    end
    else if (clk_en)
    begin
      checked++;
      if ({vid_fval, vid_lval, vid_dval} !== q1[12:10] || (q1[10] && vid_pix !== q1[9:0]))
      begin
        miscompares++;
        $display("[ERR] %0t video got %h exp %h", $time, {vid_fval, vid_lval, vid_dval, vid_pix}, q1);
      end
      q1 = q0;
      q0 = {sen_fval, sen_lval, sen_dval, 10'(f_exp(int'(sen_pix)))};
      if (!sen_fval)
      begin
        col = 0;
        row = 0;
      end
      else if (lv_d && !sen_lval)
      begin
        row++;
        col = 0;
      end
      else if (sen_lval && sen_dval)
        col++;
      lv_d = sen_lval;
    end
    if (cyc == 30000)
    begin
      miscompares++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------------------
  // Bus and stream tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      rsp = bresp;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rdx(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      rd = rdata;
      rsp = rresp;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rdx

  task automatic rdc(input logic [7:0] a, input int e);
    rdx(a);
    chk(32'(rsp), 32'(`VOT_RESP_OKAY));
    chk(rd, 32'(e));
  endtask : rdc

  task automatic wrs(input int s);
    wr(`VOT_ADDR_SRC, 32'(s));
    if (s == 0 || (s >= 4 && s <= 8))
      m_src = s;
  endtask : wrs

  // Clock enable drops at random so every stage must freeze together
  task automatic frame();
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    while (busy)
    begin
      clk_en <= ($urandom % 4) != 0;
      @(posedge sys_clk);
    end
    clk_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : frame

  task automatic end_sim();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    rd = $urandom(78665);
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc(`VOT_ADDR_SRC, 0);
    rdc(`VOT_ADDR_GAIN, 32'h0000_0400);
    rdc(`VOT_ADDR_OFFS, 0);
    wr(`VOT_ADDR_EXPO, 32'h0000_0001);
    for (int i = 0; i < 4; i++)
    begin
      wr(`VOT_ADDR_GAIN, 32'(ga[i]));
      m_gain = ga[i];
      wr(`VOT_ADDR_OFFS, 32'(oa[i]));
      m_offs = oa[i];
      frame();
    end
    // Ramp sources 4, 5, 6 keep the stored gain and offset and turn off exposure correction
    for (int s = 4; s <= 6; s++)
    begin
      wrs(s);
      rdc(`VOT_ADDR_GAIN, m_gain);
      rdc(`VOT_ADDR_OFFS, m_offs);
      rdc(`VOT_ADDR_STAT, (s << `VOT_STAT_CNT_LSB) | 1);
      chk(32'(pat_active), 32'h0000_0001);
      chk(32'(expo_corr_en), 32'h0000_0000);
      frame();
    end
    wrs(0);
    chk(32'(pat_active), 32'h0000_0000);
    chk(32'(expo_corr_en), 32'h0000_0001);
    frame();
    wr(8'h20, 32'h0000_0001);
    chk(32'(rsp), 32'(`VOT_RESP_SLVERR));
    rdx(8'h20);
    chk({rd[29:0], rsp}, 32'(`VOT_RESP_SLVERR));
    wr(`VOT_ADDR_GAIN, 32'h0000_0100);
    m_gain = 1024;
    rdc(`VOT_ADDR_GAIN, 32'h0000_0400);
    wrs(2);
    rdc(`VOT_ADDR_SRC, 0);
    frame();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
